/* sprg_pkg.sv */
`default_nettype none
package sprg_pkg;
   // register port geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [4:0] ADDR_FAULT_X   = 5'h06;
   localparam logic [4:0] ADDR_FAULT_Y   = 5'h07;
   localparam logic [4:0] ADDR_POS_HIGH  = 5'h08;
   localparam logic [4:0] ADDR_POS_LOW   = 5'h09;
   localparam logic [4:0] ADDR_GATE_CUR  = 5'h0A;
   localparam logic [4:0] ADDR_DEAD_PH2  = 5'h0B;
   localparam logic [4:0] ADDR_TURN_OFF  = 5'h0C;
   localparam logic [4:0] ADDR_PHASE_ONE = 5'h0D;

   // values after reset
   localparam logic [7:0] RST_GATE_CUR  = 8'hFF;
   localparam logic [7:0] RST_DEAD_PH2  = 8'h40;
   localparam logic [7:0] RST_TURN_OFF  = 8'h11;
   localparam logic [7:0] RST_PHASE_ONE = 8'h11;
   localparam logic [7:0] RST_ZERO      = 8'h00;

   // writable bits of the two timing registers with holes at bits 7 and 3
   localparam logic [7:0] TIMING_MASK = 8'h77;

   // field positions
   localparam int GATE_ON_LSB   = 4;
   localparam int DEAD_LSB      = 6;
   localparam int HI_LSB        = 3;
   localparam int HI_OFF_LSB    = 4;
   localparam int PARITY_BIT    = 7;

   // dead time choices in microseconds
   localparam int DEAD_1_US = 40;
   localparam int DEAD_2_US = 80;
   localparam int DEAD_3_US = 160;
   // clock rate in MHz, 100 ns period
   localparam int CLK_MHZ   = 10;
   // dead time counts in clock cycles
   localparam logic [11:0] DEAD_1_CYC = 12'(DEAD_1_US * CLK_MHZ);
   localparam logic [11:0] DEAD_2_CYC = 12'(DEAD_2_US * CLK_MHZ);
   localparam logic [11:0] DEAD_3_CYC = 12'(DEAD_3_US * CLK_MHZ);
endpackage : sprg_pkg
`default_nettype wire

/* sprg_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module sprg_regs (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // register port from the serial front end
   input  wire logic [4:0]  reg_addr,
   input  wire logic        reg_wr_en,
   input  wire logic [7:0]  reg_wr_data,
   input  wire logic        reg_rd_en,
   output logic      [7:0]  reg_rd_data_q,
   // device state
   input  wire logic [8:0]  step_position,
   input  wire logic        sleep_mode,
   input  wire logic [5:0]  fault_x_event,
   input  wire logic [5:0]  fault_y_event,
   // gate pre-driver settings
   output logic      [3:0]  gate_charge_code_q,
   output logic      [3:0]  gate_discharge_code_q,
   output logic      [1:0]  dead_time_sel_q,
   output logic      [11:0] dead_time_cycles_q,
   output logic      [2:0]  high_side_phase_two_q,
   output logic      [2:0]  low_side_phase_two_q,
   output logic      [2:0]  high_side_turnoff_q,
   output logic      [2:0]  low_side_turnoff_q,
   output logic      [2:0]  high_side_phase_one_q,
   output logic      [2:0]  low_side_phase_one_q
);

   // stored register images
   logic [7:0] gate_cur_q;     // charge and discharge codes
   logic [7:0] dead_ph2_q;     // dead time and t2
   logic [7:0] turn_off_q;     // turn-off durations
   logic [7:0] phase_one_q;    // t1 durations
   logic [5:0] fault_x_q;      // latched x bridge errors, bits 6:1
   logic [5:0] fault_y_q;      // latched y bridge errors, bits 6:1
   logic [5:0] fault_x_d;
   logic [5:0] fault_y_d;
   logic [7:0] rd_mux;         // combinational read value

   // write decode shared by all writable registers
   // a plain equality, kept as a function so the write and clear decodes read alike
   function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
      hit = (a == target);
   endfunction : hit

   // dead time code to cycle count, used by the settings output
   // the counts assume the fixed 10 MHz clock; another clock needs new constants
   function automatic logic [11:0] dead_cycles(input logic [1:0] sel);
      case (sel)
         2'b00:   dead_cycles = 12'h000;
         2'b01:   dead_cycles = sprg_pkg::DEAD_1_CYC;
         2'b10:   dead_cycles = sprg_pkg::DEAD_2_CYC;
         default: dead_cycles = sprg_pkg::DEAD_3_CYC;
      endcase
   endfunction : dead_cycles

   // latched status byte with even parity on top
   // bit 0 carries no flag and always reads zero
   function automatic logic [7:0] status_byte(input logic [5:0] f);
      status_byte = {^f, f, 1'b0};
   endfunction : status_byte

   // gate current register
   // all eight bits are writable, this register has no holes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gate_cur_q <= sprg_pkg::RST_GATE_CUR;
      end else if (reg_wr_en && hit(reg_addr, sprg_pkg::ADDR_GATE_CUR)) begin
         gate_cur_q <= reg_wr_data;
      end
   end

   // dead time and t2 register
   // bits 7:6 feed the dead time decode, bits 5:0 the two t2 codes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dead_ph2_q <= sprg_pkg::RST_DEAD_PH2;
      end else if (reg_wr_en && hit(reg_addr, sprg_pkg::ADDR_DEAD_PH2)) begin
         dead_ph2_q <= reg_wr_data;
      end
   end

   // turn-off register; holes are masked so they read zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         turn_off_q <= sprg_pkg::RST_TURN_OFF;
      end else if (reg_wr_en && hit(reg_addr, sprg_pkg::ADDR_TURN_OFF)) begin
         turn_off_q <= reg_wr_data & sprg_pkg::TIMING_MASK;
      end
   end

   // t1 register; same masking as turn-off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase_one_q <= sprg_pkg::RST_PHASE_ONE;
      end else if (reg_wr_en && hit(reg_addr, sprg_pkg::ADDR_PHASE_ONE)) begin
         phase_one_q <= reg_wr_data & sprg_pkg::TIMING_MASK;
      end
   end

   // latched error next state: a new event beats a clearing read
   // clearing first and setting after keeps an event that lands on the read edge
   // sleep blocks only the clear; the read data is returned as usual
   always_comb begin
      fault_x_d = fault_x_q;
      fault_y_d = fault_y_q;
      if (reg_rd_en && !sleep_mode) begin
         if (hit(reg_addr, sprg_pkg::ADDR_FAULT_X)) begin
            fault_x_d = 6'h0;
         end
         if (hit(reg_addr, sprg_pkg::ADDR_FAULT_Y)) begin
            fault_y_d = 6'h0;
         end
      end
      fault_x_d = fault_x_d | fault_x_event;
      fault_y_d = fault_y_d | fault_y_event;
   end

   // latched error flops
   // apart from a clearing read, only reset drops a flag
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fault_x_q <= 6'h0;
         fault_y_q <= 6'h0;
      end else begin
         fault_x_q <= fault_x_d;
         fault_y_q <= fault_y_d;
      end
   end

   // read multiplexer; the value returned is the one seen before any clear
   // position reads bypass the register images, so the read data register takes the live value
   always_comb begin
      case (reg_addr)
         sprg_pkg::ADDR_FAULT_X:   rd_mux = status_byte(fault_x_q);
         sprg_pkg::ADDR_FAULT_Y:   rd_mux = status_byte(fault_y_q);
         sprg_pkg::ADDR_POS_HIGH:  rd_mux = step_position[8:1];
         sprg_pkg::ADDR_POS_LOW:   rd_mux = step_position[7:0];
         sprg_pkg::ADDR_GATE_CUR:  rd_mux = gate_cur_q;
         sprg_pkg::ADDR_DEAD_PH2:  rd_mux = dead_ph2_q;
         sprg_pkg::ADDR_TURN_OFF:  rd_mux = turn_off_q;
         sprg_pkg::ADDR_PHASE_ONE: rd_mux = phase_one_q;
         // unmapped addresses read zero
         default:                  rd_mux = sprg_pkg::RST_ZERO;
      endcase
   end

   // read data register, loaded only on a read strobe
   // holding between strobes keeps the answer steady for the serial front end
   // limitation: the two position halves come from different edges, not one snapshot
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rd_data_q <= sprg_pkg::RST_ZERO;
      end else if (reg_rd_en) begin
         reg_rd_data_q <= rd_mux;
      end
   end

   // settings outputs, one cycle behind the stored images
   // one cycle of latency is traded for outputs that come straight from flops
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         // reset values, apart from the DEAD_1_CYC dead time count, are cut from the register images so the two always agree
         gate_charge_code_q    <= sprg_pkg::RST_GATE_CUR[7:4];
         gate_discharge_code_q <= sprg_pkg::RST_GATE_CUR[3:0];
         dead_time_sel_q       <= sprg_pkg::RST_DEAD_PH2[7:6];
         dead_time_cycles_q    <= sprg_pkg::DEAD_1_CYC;
         high_side_phase_two_q <= sprg_pkg::RST_DEAD_PH2[5:3];
         low_side_phase_two_q  <= sprg_pkg::RST_DEAD_PH2[2:0];
         high_side_turnoff_q   <= sprg_pkg::RST_TURN_OFF[6:4];
         low_side_turnoff_q    <= sprg_pkg::RST_TURN_OFF[2:0];
         high_side_phase_one_q <= sprg_pkg::RST_PHASE_ONE[6:4];
         low_side_phase_one_q  <= sprg_pkg::RST_PHASE_ONE[2:0];
      end else begin
         gate_charge_code_q    <= gate_cur_q[sprg_pkg::GATE_ON_LSB +: 4];
         gate_discharge_code_q <= gate_cur_q[3:0];
         dead_time_sel_q       <= dead_ph2_q[sprg_pkg::DEAD_LSB +: 2];
         dead_time_cycles_q    <= dead_cycles(dead_ph2_q[sprg_pkg::DEAD_LSB +: 2]);
         high_side_phase_two_q <= dead_ph2_q[sprg_pkg::HI_LSB +: 3];
         low_side_phase_two_q  <= dead_ph2_q[2:0];
         // the unused bits 7 and 3 never reach these fields
         // turn-off and t1 fields
         high_side_turnoff_q   <= turn_off_q[sprg_pkg::HI_OFF_LSB +: 3];
         low_side_turnoff_q    <= turn_off_q[2:0];
         high_side_phase_one_q <= phase_one_q[sprg_pkg::HI_OFF_LSB +: 3];
         low_side_phase_one_q  <= phase_one_q[2:0];
      end
   end

endmodule : sprg_regs
`default_nettype wire

/* sprg_props.sv */
`timescale 1ns/1ns
`default_nettype none
module sprg_props (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // register port
   input wire logic        reg_wr_en,
   input wire logic        reg_rd_en,
   input wire logic [4:0]  reg_addr,
   input wire logic [7:0]  reg_wr_data,
   input wire logic [7:0]  reg_rd_data_q,
   // live position
   input wire logic [8:0]  step_position,
   // settings
   input wire logic [3:0]  gate_charge_code_q,
   input wire logic [3:0]  gate_discharge_code_q,
   input wire logic [1:0]  dead_time_sel_q,
   input wire logic [11:0] dead_time_cycles_q,
   input wire logic [2:0]  high_side_phase_two_q,
   input wire logic [2:0]  low_side_phase_two_q,
   input wire logic [2:0]  high_side_turnoff_q,
   input wire logic [2:0]  low_side_turnoff_q,
   input wire logic [2:0]  high_side_phase_one_q,
   input wire logic [2:0]  low_side_phase_one_q
);
   // one clock domain, so one default clock and reset for every property
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // position reads return the live value of the strobe cycle
   a_pos_high: assert property (reg_rd_en && reg_addr == 5'h08
      |=> reg_rd_data_q == 8'($past(step_position) >> 1)) else $error("high position");
   a_pos_low: assert property (reg_rd_en && reg_addr == 5'h09
      |=> reg_rd_data_q == 8'($past(step_position))) else $error("low position");
   a_hole_zero: assert property (reg_rd_en && reg_addr inside {5'h0C, 5'h0D}
      |=> (reg_rd_data_q & 8'h88) == 8'h00) else $error("unused bit set");
   a_dead_decode: assert property (dead_time_cycles_q == (dead_time_sel_q == 2'd0
      ? 12'h000 : 12'h190 << (dead_time_sel_q - 2'd1))) else $error("dead time count");
   // settings show a write one edge after it is taken; the check samples it two edges on
   a_gate_write: assert property (reg_wr_en && reg_addr == 5'h0A |-> ##2
      {gate_charge_code_q, gate_discharge_code_q} == $past(reg_wr_data, 2)) else $error("gate");
   a_phase_two: assert property (reg_wr_en && reg_addr == 5'h0B |-> ##2
      {dead_time_sel_q, high_side_phase_two_q, low_side_phase_two_q} == $past(reg_wr_data, 2))
      else $error("phase two");
   a_turn_off: assert property (reg_wr_en && reg_addr == 5'h0C |-> ##2
      {1'b0, high_side_turnoff_q, 1'b0, low_side_turnoff_q} == ($past(reg_wr_data, 2) & 8'h77))
      else $error("turn off");
   a_phase_one: assert property (reg_wr_en && reg_addr == 5'h0D |-> ##2
      {1'b0, high_side_phase_one_q, 1'b0, low_side_phase_one_q} == ($past(reg_wr_data, 2) & 8'h77))
      else $error("phase one");
   c_long_dead: cover property (dead_time_sel_q == 2'b11);
   c_pos_read: cover property (reg_rd_en && reg_addr == 5'h09);
   c_hole_write: cover property (reg_wr_en && reg_addr == 5'h0D && reg_wr_data[3]);
endmodule : sprg_props
bind sprg_regs sprg_props props_u (.*);
`default_nettype wire

/* sprg_host.sv */
`timescale 1ns/1ns
`default_nettype none
module sprg_host (
   // clock and read answer
   input  wire logic       clk,
   input  wire logic [7:0] reg_rd_data_q,
   // strobes toward the block
   output logic            reg_wr_en = 1'b0,
   output logic            reg_rd_en = 1'b0,
   output logic      [4:0] reg_addr = 5'h00,
   output logic      [7:0] reg_wr_data = 8'h00
);
   // one strobe held over the taking edge; released strobes drop to zero, address and data show the inverse, never stale data
   task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(negedge clk);
      {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = {wr, !wr, a, d};
      @(posedge clk);
      @(negedge clk);
      q = reg_rd_data_q;
      {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = {2'b00, ~a, ~d};
   endtask : xfer
endmodule : sprg_host
`default_nettype wire

/* step_position_and_gate_timing_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module step_position_and_gate_timing_regs_tb;
   // bench-driven inputs and observed outputs
   logic        clk = 1'b0, reset = 1'b1, sleep_mode = 1'b0, reg_wr_en, reg_rd_en;
   logic [8:0]  step_position = 9'h000;
   logic [5:0]  fault_x_event = 6'h00, fault_y_event = 6'h00;
   logic [3:0]  gate_charge_code_q, gate_discharge_code_q;
   logic [1:0]  dead_time_sel_q;
   logic [2:0]  high_side_phase_two_q, low_side_phase_two_q, high_side_turnoff_q;
   logic [2:0]  low_side_turnoff_q, high_side_phase_one_q, low_side_phase_one_q;
   logic [4:0]  reg_addr, a;
   logic [7:0]  reg_wr_data, reg_rd_data_q, q;
   logic [11:0] dead_time_cycles_q;
   logic [31:0] seed = 32'h811e_e4ec, r;
   int          n_mismatch = 0, checks = 0;
   always #50 clk = ~clk;
   sprg_host host_u (.*);
   sprg_regs dut_u (.*);
   // settings outputs regrouped into the layout of their registers
   wire [7:0]   img_gate = {gate_charge_code_q, gate_discharge_code_q};
   wire [7:0]   img_ph2  = {dead_time_sel_q, high_side_phase_two_q, low_side_phase_two_q};
   wire [7:0]   img_off  = {1'b0, high_side_turnoff_q, 1'b0, low_side_turnoff_q};
   wire [7:0]   img_one  = {1'b0, high_side_phase_one_q, 1'b0, low_side_phase_one_q};
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // timing registers keep only their two 3-bit fields
   function automatic logic [7:0] exp_rd(input logic [4:0] ad, input logic [7:0] d);
      return (ad >= 5'h0C) ? (d & 8'h77) : d;
   endfunction : exp_rd
   // dead time of 40, 80 or 160 us at ten cycles per microsecond
   function automatic logic [11:0] exp_dead(input logic [1:0] sel);
      case (sel)
         2'd0:    return 12'd0;
         2'd1:    return 12'd400;
         2'd2:    return 12'd800;
         default: return 12'd1600;
      endcase
   endfunction : exp_dead
   task automatic chk(input logic [11:0] seen, input logic [11:0] want);
      checks++;
      if (seen !== want) n_mismatch++;
      if (seen !== want) $display("[FAIL] %0t seen %h want %h", $time, seen, want);
   endtask : chk
   task automatic final_report();
      if (n_mismatch == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   // register images and settings outputs right after a reset
   task automatic check_reset();
      for (int i = 0; i < 4; i++) begin
         host_u.xfer(1'b0, 5'(10 + i), 8'h00, q);
         chk(q, 8'(32'hff40_1111 >> (24 - 8 * i)));
      end
      chk(img_gate, 8'hff);
      chk(dead_time_cycles_q, 12'd400);
      chk(img_ph2, 8'h40);
      chk(img_off, 8'h11);
      chk(img_one, 8'h11);
   endtask : check_reset
   // watchdog, far beyond the fewer than a thousand cycles the run needs
   initial begin
      #2000000;
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      check_reset();
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         a = 5'(10 + r[9:8]);
         step_position = r[24:16];
         host_u.xfer(1'b1, a, r[7:0], q);
         // read-only place must ignore this write
         host_u.xfer(1'b1, 5'h08, r[15:8], q);
         host_u.xfer(1'b0, a, 8'h00, q);
         chk(q, exp_rd(a, r[7:0]));
         // settings outputs follow the fields just written
         case (a)
            5'h0A: begin
               chk(img_gate, r[7:0]);
            end
            5'h0B: begin
               chk(img_ph2, r[7:0]);
               chk(dead_time_cycles_q, exp_dead(r[7:6]));
            end
            5'h0C: begin
               chk(img_off, exp_rd(a, r[7:0]));
            end
            default: begin
               chk(img_one, exp_rd(a, r[7:0]));
            end
         endcase
         host_u.xfer(1'b0, 5'h08, 8'h00, q);
         chk(q, step_position[8:1]);
         // position moves between the halves, nothing is held
         step_position = r[31:23];
         host_u.xfer(1'b0, 5'h09, 8'h00, q);
         chk(q, step_position[7:0]);
         host_u.xfer(1'b0, 5'(31 - r[3:0]), 8'h00, q);
         chk(q, 8'h00);
      end
      // corner case: both hole bits set at once
      host_u.xfer(1'b1, 5'h0D, 8'hff, q);
      host_u.xfer(1'b0, 5'h0D, 8'h00, q);
      chk(q, 8'h77);
      chk(img_one, 8'h77);
      fault_x_event = 6'h05;
      @(negedge clk) fault_x_event = 6'h00;
      // two reads asleep keep the flags, the next clears them
      for (int i = 0; i < 4; i++) begin
         sleep_mode = 1'(i < 2);
         host_u.xfer(1'b0, 5'h06, 8'h00, q);
         chk(q, 8'(32'h0a0a_0a00 >> (24 - 8 * i)));
      end
      // an event on the clearing read edge survives; odd flag count sets parity
      fault_y_event = 6'h2c;
      host_u.xfer(1'b0, 5'h07, 8'h00, q);
      chk(q, 8'hd8);
      fault_y_event = 6'h00;
      host_u.xfer(1'b0, 5'h07, 8'h00, q);
      chk(q, 8'hd8);
      host_u.xfer(1'b0, 5'h07, 8'h00, q);
      chk(q, 8'h00);
      // a raised flag and written settings must not outlive a reset in mid-run
      fault_x_event = 6'h21;
      @(negedge clk) fault_x_event = 6'h00;
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      check_reset();
      host_u.xfer(1'b0, 5'h06, 8'h00, q);
      chk(q, 8'h00);
      final_report();
   end
endmodule : step_position_and_gate_timing_regs_tb
`default_nettype wire
